// ---- rtl/lapblc_link_ctrl.sv ----
// link level control: start-up, retransmission, window, probing, timeouts
// Function
// - restart unbalanced sends SARM start command
// - restart balanced sends SABM start command
// - restart disconnect sends DISC, link disconnected
// - retransmission interval 2..80 units of 10ms
// - retry limit 2..50 reached restarts link
// - outstanding frames never exceed link window
// - default packet window 1..7, reset 2
// - narrow numbering uses sequence 0..7
// - wide numbering uses sequence 0..127
// - per-link modulus select, narrow or wide
// - idle 3 seconds sends RR poll
// - call response timeout 2..200 seconds
// - CRC errors beyond threshold raise notification
// - multiplexed port with boot sends load sequence
// - extended facility option passes facility codes
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lapblc_link_ctrl #(
  parameter int unsigned TICK_CYCLES = lapblc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame transmit request
  output logic txValid,
  input wire logic txReady,
  output lapblc_pkg::lapblc_frame_t txKind,
  output logic txPoll,
  output logic [6:0] txNs,
  output logic [15:0] txDesc,
  // information frames from level 3
  input wire logic sendValid,
  input wire logic [15:0] sendDesc,
  output logic sendReady,
  // receiver events
  input wire logic rxAck,
  input wire logic [6:0] rxNr,
  input wire logic rxUa,
  input wire logic rxActivity,
  input wire logic crcErr,
  // channel connection timing
  input wire logic callStart,
  input wire logic callResp,
  output logic callTimeout,
  // status and configuration out
  output logic errNotify,
  output logic linkUp,
  output logic wideModulus,
  output logic extFacilityEn,
  output logic [2:0] packetWindowDefault
);

  typedef struct packed {
    logic [1:0] initSel;
    logic wide;
    logic mux;
    logic boot;
    logic extf;
    logic [7:0] t1;
    logic [7:0] tries;
    logic [2:0] lwin;
    logic [2:0] pwin;
    logic [7:0] callSec;
    logic [7:0] errThr;
    logic [2:0] probe;
    lapblc_pkg::lapblc_state_t st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txValid;
    lapblc_pkg::lapblc_frame_t txKind;
    logic txPoll;
    logic [6:0] txNs;
    logic [15:0] txDesc;
    logic sendReady;
    logic [6:0] vs;
    logic [6:0] va;
    logic [7:0] retry;
    logic retxPend;
    logic [21:0] tick;
    logic [7:0] t1Cnt;
    logic [8:0] idleCnt;
    logic [14:0] callCnt;
    logic callRun;
    logic callTo;
    logic [7:0] crcCnt;
    logic errNote;
  } lapblc_regs_t;

  lapblc_regs_t q_r;
  lapblc_regs_t q_nxt;
  logic [15:0] memRd;
  logic memWr;

  function automatic logic [7:0] clampv(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampv

  lapblc_desc_mem u_mem (
    .clk(clk),
    .arst_n(arst_n),
    .wrEn(memWr),
    .wrAddr(q_r.vs),
    .wrData(sendDesc),
    .rdAddr(q_r.va),
    .rdData(memRd)
  );

  always_comb
  begin
    logic tickHit;
    logic setup;
    logic acc;
    logic restart;
    logic txFree;
    logic accept;
    logic t1Exp;
    logic [6:0] mask;
    logic [6:0] outst;
    logic [6:0] outNxt;
    logic [7:0] crcNew;
    tickHit = 1'b0;
    setup = 1'b0;
    acc = 1'b0;
    restart = 1'b0;
    txFree = 1'b0;
    accept = 1'b0;
    t1Exp = 1'b0;
    mask = 7'h00;
    outst = 7'h00;
    outNxt = 7'h00;
    crcNew = 8'h00;
    q_nxt = q_r;
    q_nxt.pready = 1'b0;
    q_nxt.pslverr = 1'b0;
    q_nxt.callTo = 1'b0;
    q_nxt.errNote = 1'b0;
    memWr = 1'b0;

    // 10 ms time base
    tickHit = (q_r.tick == 22'(TICK_CYCLES - 1));
    q_nxt.tick = tickHit ? 22'h000000 : q_r.tick + 22'h000001;

    mask = q_r.wide ? lapblc_pkg::WIDE_MASK : lapblc_pkg::NARROW_MASK;
    outst = (q_r.vs - q_r.va) & mask;

    // apb: answer in the access cycle after every setup
    setup = psel & ~penable;
    acc = psel & penable & q_r.pready;
    if (setup)
    begin
      q_nxt.pready = 1'b1;
      q_nxt.prdata = 32'h00000000;
      unique case (paddr)
        lapblc_pkg::CTRL_OFS:
        begin
          q_nxt.prdata[lapblc_pkg::CTRL_INIT_LSB +: 2] = q_r.initSel;
          q_nxt.prdata[lapblc_pkg::CTRL_WIDE] = q_r.wide;
          q_nxt.prdata[lapblc_pkg::CTRL_MUX] = q_r.mux;
          q_nxt.prdata[lapblc_pkg::CTRL_BOOT] = q_r.boot;
          q_nxt.prdata[lapblc_pkg::CTRL_EXTF] = q_r.extf;
        end
        lapblc_pkg::TIMER_OFS:
        begin
          q_nxt.prdata[lapblc_pkg::TIM_T1_LSB +: 8] = q_r.t1;
          q_nxt.prdata[lapblc_pkg::TIM_TRIES_LSB +: 8] = q_r.tries;
          q_nxt.prdata[lapblc_pkg::TIM_LWIN_LSB +: 3] = q_r.lwin;
          q_nxt.prdata[lapblc_pkg::TIM_PWIN_LSB +: 3] = q_r.pwin;
        end
        lapblc_pkg::LIMIT_OFS:
        begin
          q_nxt.prdata[lapblc_pkg::LIM_CALL_LSB +: 8] = q_r.callSec;
          q_nxt.prdata[lapblc_pkg::LIM_ERR_LSB +: 8] = q_r.errThr;
          q_nxt.prdata[lapblc_pkg::LIM_PROBE_LSB +: 3] = q_r.probe;
        end
        lapblc_pkg::STAT_OFS:
        begin
          q_nxt.prdata[lapblc_pkg::STA_STATE_LSB +: 3] = q_r.st;
          q_nxt.prdata[lapblc_pkg::STA_UP] = (q_r.st == lapblc_pkg::ST_UP);
          q_nxt.prdata[lapblc_pkg::STA_OUT_LSB +: 7] = outst;
          q_nxt.prdata[lapblc_pkg::STA_RETRY_LSB +: 8] = q_r.retry;
          q_nxt.prdata[lapblc_pkg::STA_CRC_LSB +: 8] = q_r.crcCnt;
        end
        default:
        begin
          q_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (acc & pwrite)
    begin
      unique case (paddr)
        lapblc_pkg::CTRL_OFS:
        begin
          q_nxt.initSel = pwdata[lapblc_pkg::CTRL_INIT_LSB +: 2];
          q_nxt.wide = pwdata[lapblc_pkg::CTRL_WIDE];
          q_nxt.mux = pwdata[lapblc_pkg::CTRL_MUX];
          q_nxt.boot = pwdata[lapblc_pkg::CTRL_BOOT];
          q_nxt.extf = pwdata[lapblc_pkg::CTRL_EXTF];
          restart = pwdata[lapblc_pkg::CTRL_RESTART];
        end
        lapblc_pkg::TIMER_OFS:
        begin
          q_nxt.t1 = clampv(pwdata[lapblc_pkg::TIM_T1_LSB +: 8], lapblc_pkg::T1_MIN,
                            lapblc_pkg::T1_MAX);
          q_nxt.tries = clampv(pwdata[lapblc_pkg::TIM_TRIES_LSB +: 8], lapblc_pkg::TRIES_MIN,
                               lapblc_pkg::TRIES_MAX);
          q_nxt.lwin = 3'(clampv({5'h00, pwdata[lapblc_pkg::TIM_LWIN_LSB +: 3]},
                                 lapblc_pkg::WIN_MIN, lapblc_pkg::WIN_MAX));
          q_nxt.pwin = 3'(clampv({5'h00, pwdata[lapblc_pkg::TIM_PWIN_LSB +: 3]},
                                 lapblc_pkg::WIN_MIN, lapblc_pkg::WIN_MAX));
        end
        lapblc_pkg::LIMIT_OFS:
        begin
          q_nxt.callSec = clampv(pwdata[lapblc_pkg::LIM_CALL_LSB +: 8], lapblc_pkg::CALL_MIN,
                                 lapblc_pkg::CALL_MAX);
          q_nxt.errThr = clampv(pwdata[lapblc_pkg::LIM_ERR_LSB +: 8], lapblc_pkg::ERR_MIN,
                                lapblc_pkg::ERR_MAX);
          q_nxt.probe = 3'(clampv({5'h00, pwdata[lapblc_pkg::LIM_PROBE_LSB +: 3]}, 8'h00,
                                  lapblc_pkg::PROBE_MAX));
        end
        default:
        begin
        end
      endcase
    end

    // transmit handshake
    if (q_r.txValid & txReady)
    begin
      q_nxt.txValid = 1'b0;
    end
    txFree = ~q_r.txValid;

    // retransmission timer, runs while an answer is awaited
    if ((q_r.st == lapblc_pkg::ST_WAIT) ||
        ((q_r.st == lapblc_pkg::ST_UP) && (outst != 7'h00)))
    begin
      if (tickHit)
      begin
        q_nxt.t1Cnt = q_r.t1Cnt + 8'h01;
        t1Exp = (q_r.t1Cnt + 8'h01 >= q_r.t1);
        if (t1Exp)
        begin
          q_nxt.t1Cnt = 8'h00;
        end
      end
    end
    else
    begin
      q_nxt.t1Cnt = 8'h00;
    end

    // idle counter
    if (rxActivity)
    begin
      q_nxt.idleCnt = 9'h000;
    end
    else if (tickHit && (q_r.idleCnt != lapblc_pkg::IDLE_TICKS))
    begin
      q_nxt.idleCnt = q_r.idleCnt + 9'h001;
    end

    // crc error counting and notification
    if (crcErr)
    begin
      crcNew = (q_r.crcCnt == 8'hFF) ? 8'hFF : q_r.crcCnt + 8'h01;
      q_nxt.crcCnt = crcNew;
      q_nxt.errNote = (crcNew > q_r.errThr);
    end

    // channel response timeout
    if (callStart)
    begin
      q_nxt.callRun = 1'b1;
      q_nxt.callCnt = 15'h0000;
    end
    else if (callResp)
    begin
      q_nxt.callRun = 1'b0;
    end
    else if (q_r.callRun && tickHit)
    begin
      q_nxt.callCnt = q_r.callCnt + 15'h0001;
      if (q_r.callCnt + 15'h0001 >= 15'(q_r.callSec) * 15'(lapblc_pkg::TICKS_PER_SEC))
      begin
        q_nxt.callTo = 1'b1;
        q_nxt.callRun = 1'b0;
      end
    end

    // link state machine
    unique case (q_r.st)
      lapblc_pkg::ST_DOWN, lapblc_pkg::ST_DISC:
      begin
      end
      lapblc_pkg::ST_INIT:
      begin
        if (txFree)
        begin
          q_nxt.txValid = 1'b1;
          q_nxt.txPoll = 1'b1;
          q_nxt.txNs = 7'h00;
          q_nxt.txDesc = 16'h0000;
          q_nxt.t1Cnt = 8'h00;
          if (q_r.initSel == lapblc_pkg::INIT_SARM)
          begin
            q_nxt.txKind = lapblc_pkg::FK_SARM;
            q_nxt.st = lapblc_pkg::ST_WAIT;
          end
          else if (q_r.initSel == lapblc_pkg::INIT_DISC)
          begin
            q_nxt.txKind = lapblc_pkg::FK_DISC;
            q_nxt.st = lapblc_pkg::ST_DISC;
          end
          else
          begin
            q_nxt.txKind = lapblc_pkg::FK_SABM;
            q_nxt.st = lapblc_pkg::ST_WAIT;
          end
        end
      end
      lapblc_pkg::ST_WAIT:
      begin
        if (rxUa)
        begin
          q_nxt.retry = 8'h00;
          q_nxt.st = (q_r.mux & q_r.boot) ? lapblc_pkg::ST_BOOT : lapblc_pkg::ST_UP;
        end
        else if (t1Exp)
        begin
          q_nxt.retry = (q_r.retry + 8'h01 >= q_r.tries) ? 8'h00 : q_r.retry + 8'h01;
          q_nxt.st = lapblc_pkg::ST_INIT;
        end
      end
      lapblc_pkg::ST_BOOT:
      begin
        if (txFree)
        begin
          q_nxt.txValid = 1'b1;
          q_nxt.txKind = lapblc_pkg::FK_BOOT;
          q_nxt.txPoll = 1'b0;
          q_nxt.st = lapblc_pkg::ST_UP;
        end
      end
      lapblc_pkg::ST_UP:
      begin
        if (t1Exp)
        begin
          q_nxt.retxPend = 1'b1;
        end
        if (rxAck && (rxNr & mask) != q_r.va && (((rxNr - q_r.va) & mask) <= outst))
        begin
          q_nxt.va = rxNr & mask;
          q_nxt.retry = 8'h00;
          q_nxt.t1Cnt = 8'h00;
          q_nxt.retxPend = 1'b0;
        end
        accept = q_r.sendReady & sendValid;
        if (accept)
        begin
          memWr = 1'b1;
          q_nxt.txValid = 1'b1;
          q_nxt.txKind = lapblc_pkg::FK_INFO;
          q_nxt.txPoll = 1'b0;
          q_nxt.txNs = q_r.vs;
          q_nxt.txDesc = sendDesc;
          q_nxt.vs = (q_r.vs + 7'h01) & mask;
          q_nxt.idleCnt = 9'h000;
        end
        else if (q_r.retxPend && txFree)
        begin
          q_nxt.retxPend = 1'b0;
          if (q_r.retry >= q_r.tries)
          begin
            restart = 1'b1;
          end
          else
          begin
            q_nxt.txValid = 1'b1;
            q_nxt.txKind = lapblc_pkg::FK_INFO;
            q_nxt.txPoll = 1'b1;
            q_nxt.txNs = q_r.va;
            q_nxt.txDesc = memRd;
            q_nxt.retry = q_r.retry + 8'h01;
            q_nxt.idleCnt = 9'h000;
          end
        end
        else if (txFree && (q_r.probe != 3'h0) && (q_r.idleCnt == lapblc_pkg::IDLE_TICKS))
        begin
          q_nxt.txValid = 1'b1;
          q_nxt.txKind = lapblc_pkg::FK_RR;
          q_nxt.txPoll = 1'b1;
          q_nxt.txNs = 7'h00;
          q_nxt.idleCnt = 9'h000;
        end
      end
      default:
      begin
        q_nxt.st = lapblc_pkg::ST_DOWN;
      end
    endcase

    // restart by software or by link failure
    if (restart)
    begin
      q_nxt.st = lapblc_pkg::ST_INIT;
      q_nxt.vs = 7'h00;
      q_nxt.va = 7'h00;
      q_nxt.retry = 8'h00;
      q_nxt.t1Cnt = 8'h00;
      q_nxt.retxPend = 1'b0;
    end

    outNxt = (q_nxt.vs - q_nxt.va) & mask;
    q_nxt.sendReady = (q_nxt.st == lapblc_pkg::ST_UP) && ~q_nxt.txValid &&
                      (outNxt < {4'h0, q_r.lwin}) && ~accept;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_r <= '0;
      q_r.initSel <= lapblc_pkg::INIT_RST;
      q_r.t1 <= lapblc_pkg::T1_RST;
      q_r.tries <= lapblc_pkg::TRIES_RST;
      q_r.lwin <= lapblc_pkg::LWIN_RST;
      q_r.pwin <= lapblc_pkg::PWIN_RST;
      q_r.callSec <= lapblc_pkg::CALL_RST;
      q_r.errThr <= lapblc_pkg::ERR_RST;
      q_r.probe <= lapblc_pkg::PROBE_RST;
      q_r.st <= lapblc_pkg::ST_DOWN;
      q_r.txKind <= lapblc_pkg::FK_SARM;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign txValid = q_r.txValid;
  assign txKind = q_r.txKind;
  assign txPoll = q_r.txPoll;
  assign txNs = q_r.txNs;
  assign txDesc = q_r.txDesc;
  assign sendReady = q_r.sendReady;
  assign callTimeout = q_r.callTo;
  assign errNotify = q_r.errNote;
  assign linkUp = (q_r.st == lapblc_pkg::ST_UP);
  assign wideModulus = q_r.wide;
  assign extFacilityEn = q_r.extf;
  assign packetWindowDefault = q_r.pwin;

endmodule : lapblc_link_ctrl
`default_nettype wire

// ---- include/lapblc_pkg.sv ----
// constants, register map and types for the link control block
package lapblc_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] TIMER_OFS = 12'h004;
  localparam logic [11:0] LIMIT_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00C;

  // control register fields
  localparam int CTRL_INIT_LSB = 0;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_MUX = 3;
  localparam int CTRL_BOOT = 4;
  localparam int CTRL_EXTF = 5;
  localparam int CTRL_RESTART = 6;

  // timer register fields
  localparam int TIM_T1_LSB = 0;
  localparam int TIM_TRIES_LSB = 8;
  localparam int TIM_LWIN_LSB = 16;
  localparam int TIM_PWIN_LSB = 20;

  // limit register fields
  localparam int LIM_CALL_LSB = 0;
  localparam int LIM_ERR_LSB = 8;
  localparam int LIM_PROBE_LSB = 16;

  // status register fields
  localparam int STA_STATE_LSB = 0;
  localparam int STA_UP = 3;
  localparam int STA_OUT_LSB = 4;
  localparam int STA_RETRY_LSB = 12;
  localparam int STA_CRC_LSB = 20;

  // legal ranges
  localparam logic [7:0] T1_MIN = 8'h02;
  localparam logic [7:0] T1_MAX = 8'h50;
  localparam logic [7:0] TRIES_MIN = 8'h02;
  localparam logic [7:0] TRIES_MAX = 8'h32;
  localparam logic [7:0] WIN_MIN = 8'h01;
  localparam logic [7:0] WIN_MAX = 8'h07;
  localparam logic [7:0] CALL_MIN = 8'h02;
  localparam logic [7:0] CALL_MAX = 8'hC8;
  localparam logic [7:0] ERR_MIN = 8'h01;
  localparam logic [7:0] ERR_MAX = 8'hFA;
  localparam logic [7:0] PROBE_MAX = 8'h04;

  // values after reset
  localparam logic [1:0] INIT_RST = 2'h1;
  localparam logic [7:0] T1_RST = 8'h0A;
  localparam logic [7:0] TRIES_RST = 8'h0A;
  localparam logic [2:0] LWIN_RST = 3'h7;
  localparam logic [2:0] PWIN_RST = 3'h2;
  localparam logic [7:0] CALL_RST = 8'h1E;
  localparam logic [7:0] ERR_RST = 8'h0A;
  localparam logic [2:0] PROBE_RST = 3'h0;

  // timing
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int TICKS_PER_SEC = 1000 / TICK_MS;
  localparam int IDLE_SEC = 3;
  localparam logic [8:0] IDLE_TICKS = 9'(IDLE_SEC * TICKS_PER_SEC);

  // sequence masks
  localparam logic [6:0] NARROW_MASK = 7'h07;
  localparam logic [6:0] WIDE_MASK = 7'h7F;

  typedef enum logic [1:0] {
    INIT_SARM = 2'b00,
    INIT_SABM = 2'b01,
    INIT_DISC = 2'b10
  } lapblc_init_t;

  typedef enum logic [2:0] {
    FK_SARM = 3'b000,
    FK_SABM = 3'b001,
    FK_DISC = 3'b010,
    FK_INFO = 3'b011,
    FK_RR = 3'b100,
    FK_BOOT = 3'b101
  } lapblc_frame_t;

  typedef enum logic [2:0] {
    ST_DOWN = 3'b000,
    ST_INIT = 3'b001,
    ST_WAIT = 3'b010,
    ST_BOOT = 3'b011,
    ST_UP = 3'b100,
    ST_DISC = 3'b101
  } lapblc_state_t;

endpackage : lapblc_pkg

// ---- rtl/lapblc_desc_mem.sv ----
// descriptor store for frames awaiting acknowledgement
`timescale 1ns/1ps
`default_nettype none
module lapblc_desc_mem (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write side
  input wire logic wrEn,
  input wire logic [6:0] wrAddr,
  input wire logic [15:0] wrData,
  // read side
  input wire logic [6:0] rdAddr,
  output logic [15:0] rdData
);
  logic [15:0] mem [0:127];

  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData <= 16'h0000;
    end
    else
    begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : lapblc_desc_mem
`default_nettype wire

// ---- verif/lapblc_assertions.sv ----
// concurrent checks on the link control ports
`timescale 1ns/1ps
`default_nettype none
module lapblc_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // frame requests
  input wire logic txValid,
  input wire logic txReady,
  input wire lapblc_pkg::lapblc_frame_t txKind,
  input wire logic txPoll,
  input wire logic [6:0] txNs,
  input wire logic sendValid,
  input wire logic sendReady,
  // events and levels
  input wire logic crcErr,
  input wire logic errNotify,
  input wire logic callTimeout,
  input wire logic linkUp,
  input wire logic wideModulus,
  input wire logic [2:0] packetWindowDefault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence take_s;
    txValid && txReady;
  endsequence
  sequence offer_s;
    sendValid && sendReady;
  endsequence
  chk_apb_ready: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txKind) && $stable(txNs))
    else $error("frame request dropped or changed");
  chk_tx_gap: assert property (take_s |=> !txValid)
    else $error("frame request right after take");
  chk_send_info: assert property (offer_s |=> txValid && txKind == lapblc_pkg::FK_INFO)
    else $error("taken frame not issued");
  chk_send_up: assert property (sendReady |-> linkUp)
    else $error("send ready while link down");
  chk_narrow_ns: assert property (txValid && !wideModulus && txKind == lapblc_pkg::FK_INFO
    |-> txNs <= 7'h07)
    else $error("narrow sequence number out of range");
  chk_cmd_poll: assert property (txValid && txKind inside {lapblc_pkg::FK_SARM,
    lapblc_pkg::FK_SABM, lapblc_pkg::FK_DISC, lapblc_pkg::FK_RR} |-> txPoll)
    else $error("command frame without poll");
  chk_notify_crc: assert property (errNotify |-> $past(crcErr))
    else $error("notify without crc error");
  chk_call_pulse: assert property (callTimeout |=> !callTimeout)
    else $error("call timeout not a pulse");
  chk_pwin_legal: assert property (packetWindowDefault inside {[3'h1:3'h7]})
    else $error("packet window default illegal");
endmodule : lapblc_assertions
bind lapblc_link_ctrl lapblc_assertions u_chk (.*);
`default_nettype wire

// ---- verif/lapblc_peer_model.sv ----
// far-side framer and peer station model
`timescale 1ns/1ps
`default_nettype none
module lapblc_peer_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // frame requests
  input wire logic txValid,
  output logic txReady,
  input wire lapblc_pkg::lapblc_frame_t txKind,
  input wire logic [6:0] txNs,
  // behaviour
  input wire logic ackOn,
  input wire logic wideModulus,
  // peer answers
  output logic rxAck,
  output logic [6:0] rxNr,
  output logic rxUa
);
  logic [2:0] cnt;
  logic [1:0] uaDly;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 3'h0;
      uaDly <= 2'h0;
      txReady <= 1'b0;
      rxAck <= 1'b0;
      rxNr <= 7'h00;
      rxUa <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 3'h1;
      txReady <= cnt[1];
      rxAck <= 1'b0;
      rxNr <= ~rxNr;
      rxUa <= uaDly == 2'h1;
      if (uaDly != 2'h0)
        uaDly <= uaDly - 2'h1;
      if (txValid && txReady && txKind inside {lapblc_pkg::FK_SARM, lapblc_pkg::FK_SABM})
        uaDly <= 2'h3;
      if (txValid && txReady && txKind == lapblc_pkg::FK_INFO && ackOn)
      begin
        rxAck <= 1'b1;
        rxNr <= (txNs + 7'h01) & (wideModulus ? lapblc_pkg::WIDE_MASK : lapblc_pkg::NARROW_MASK);
      end
    end
  end
endmodule : lapblc_peer_model
`default_nettype wire

// ---- verif/test_lapb_link_control.sv ----
// self-checking bench for the link control block
`timescale 1ns/1ps
`default_nettype none
module test_lapb_link_control;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdQ, seed = 32'h94985E7B;
  logic pready, pslverr, txValid, txReady, txPoll, sendReady, rxAck, rxUa, callTimeout;
  logic errNotify, linkUp, wideModulus, extFacilityEn, lastPoll, rdE;
  logic sendValid = 1'b0, rxActivity = 1'b0, crcErr = 1'b0, ackOn = 1'b0;
  logic callStart = 1'b0, callResp = 1'b0;
  logic [15:0] sendDesc = 16'h0, txDesc, lastDesc;
  logic [6:0] txNs, rxNr, lastNs;
  logic [2:0] packetWindowDefault;
  lapblc_pkg::lapblc_frame_t txKind, lastKind;
  int num_errors = 0, checks = 0, cyc = 0, nFr = 0, nNote = 0, nCall = 0, lastT = 0, t0, m;
  lapblc_link_ctrl #(.TICK_CYCLES(20)) u_dut (.*);
  lapblc_peer_model u_peer (.*);
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    nNote += int'(errNotify === 1'b1);
    nCall += int'(callTimeout === 1'b1);
    if (txValid && txReady)
    begin
      nFr++;
      lastT = cyc;
      {lastKind, lastPoll, lastNs, lastDesc} = {txKind, txPoll, txNs, txDesc};
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] cl(input logic [7:0] v, input logic [7:0] lo, hi);
    return 32'(v < lo ? lo : (v > hi ? hi : v));
  endfunction : cl
  function automatic logic [31:0] texp(input logic [31:0] v);
    return cl(v[7:0], lapblc_pkg::T1_MIN, lapblc_pkg::T1_MAX)
      | cl(v[15:8], lapblc_pkg::TRIES_MIN, lapblc_pkg::TRIES_MAX) << 8
      | cl({5'h0, v[18:16]}, lapblc_pkg::WIN_MIN, lapblc_pkg::WIN_MAX) << 16
      | cl({5'h0, v[22:20]}, lapblc_pkg::WIN_MIN, lapblc_pkg::WIN_MAX) << 20;
  endfunction : texp
  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic check_eq(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_eq
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    {rdQ, rdE} = {prdata, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] mask, exp);
    apb(1'b0, a, 32'h0);
    check_eq(nm, rdQ & mask, exp);
  endtask : rchk
  task automatic next_frame();
    int n;
    m = nFr;
    n = 0;
    while (nFr == m && n < 8000)
    begin
      n++;
      @(posedge clk);
    end
    num_errors += int'(n == 8000);
  endtask : next_frame
  task automatic gap(input string nm, input int lo, hi);
    check_eq(nm, 32'(lastT - t0 >= lo && lastT - t0 <= hi), 32'h1);
  endtask : gap
  task automatic send_n(input int n, input logic [6:0] mask);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      sendDesc <= seed[15:0];
      sendValid <= 1'b1;
      @(posedge clk iff sendReady === 1'b1);
      sendValid <= 1'b0;
      next_frame();
      check_eq("ns", lastNs, 7'(i) & mask);
      check_eq("desc", lastDesc, seed[15:0]);
    end
  endtask : send_n
  task automatic restart(input logic [31:0] c);
    apb(1'b1, lapblc_pkg::CTRL_OFS, c | 32'h40);
    next_frame();
    check_eq("init", lastKind, c[1:0]);
    repeat (12) @(posedge clk);
  endtask : restart
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check_eq("pwin", packetWindowDefault, 32'h2);
    rchk("ctrl", lapblc_pkg::CTRL_OFS, 32'hFFFFFFFF, 32'h1);
    rchk("timer", lapblc_pkg::TIMER_OFS, 32'hFFFFFFFF, 32'h00270A0A);
    rchk("limit", lapblc_pkg::LIMIT_OFS, 32'hFFFFFFFF, 32'h00000A1E);
    rchk("stat", lapblc_pkg::STAT_OFS, 32'hFFFFFFFF, 32'h0);
    rchk("unmapped", 12'h010, 32'hFFFFFFFF, 32'h0);
    check_eq("slverr", rdE, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      apb(1'b1, lapblc_pkg::TIMER_OFS, seed);
      rchk("tclamp", lapblc_pkg::TIMER_OFS, 32'hFFFFFFFF, texp(seed));
    end
    apb(1'b1, lapblc_pkg::LIMIT_OFS, 32'h000700FF);
    rchk("lclamp", lapblc_pkg::LIMIT_OFS, 32'hFFFFFFFF, 32'h000401C8);
    apb(1'b1, lapblc_pkg::LIMIT_OFS, 32'h00000302);
    apb(1'b1, lapblc_pkg::TIMER_OFS, 32'h00333250);
    check_eq("pwin3", packetWindowDefault, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      restart(32'(i));
      check_eq("up", linkUp, 32'(i != 2));
      rchk("state", lapblc_pkg::STAT_OFS, 32'h7, i == 2 ? 32'h5 : 32'h4);
    end
    apb(1'b1, lapblc_pkg::CTRL_OFS, 32'h79);
    next_frame();
    next_frame();
    check_eq("boot", lastKind, lapblc_pkg::FK_BOOT);
    repeat (8) @(posedge clk);
    check_eq("cfg", {linkUp, extFacilityEn, wideModulus}, 32'h6);
    ackOn <= 1'b1;
    send_n(20, lapblc_pkg::NARROW_MASK);
    restart(32'h5);
    check_eq("wide", wideModulus, 32'h1);
    send_n(20, lapblc_pkg::WIDE_MASK);
    restart(32'h1);
    ackOn <= 1'b0;
    t0 = nFr;
    sendValid <= 1'b1;
    repeat (300) @(posedge clk);
    sendValid <= 1'b0;
    check_eq("window", nFr - t0, 32'h3);
    rchk("outst", lapblc_pkg::STAT_OFS, 32'hFFFFFFFF, 32'h3C);
    apb(1'b1, lapblc_pkg::TIMER_OFS, 32'h00330202);
    next_frame();
    check_eq("retx", {lastKind, lastPoll, lastNs}, {lapblc_pkg::FK_INFO, 8'h80});
    check_eq("retxdesc", lastDesc, sendDesc);
    rchk("retry1", lapblc_pkg::STAT_OFS, 32'hFF000, 32'h01000);
    t0 = lastT;
    ackOn <= 1'b1;
    next_frame();
    ackOn <= 1'b0;
    gap("t1gap", 20, 60);
    rchk("retry0", lapblc_pkg::STAT_OFS, 32'hFF7F0, 32'h00020);
    next_frame();
    check_eq("retxns", lastNs, 32'h1);
    next_frame();
    next_frame();
    check_eq("fail", lastKind, lapblc_pkg::FK_SABM);
    repeat (12) @(posedge clk);
    apb(1'b1, lapblc_pkg::LIMIT_OFS, 32'h00010302);
    next_frame();
    check_eq("probe", {lastKind, lastPoll}, {lapblc_pkg::FK_RR, 1'b1});
    t0 = lastT;
    next_frame();
    gap("idle", 5980, 6020);
    apb(1'b1, lapblc_pkg::LIMIT_OFS, 32'h00000302);
    t0 = nNote;
    repeat (5)
    begin
      crcErr <= 1'b1;
      @(posedge clk);
      crcErr <= 1'b0;
      repeat (3) @(posedge clk);
    end
    check_eq("notify", nNote - t0, 32'h2);
    rchk("crccnt", lapblc_pkg::STAT_OFS, 32'hFF00000, 32'h0500000);
    callStart <= 1'b1;
    @(posedge clk);
    callStart <= 1'b0;
    t0 = cyc;
    repeat (4100) @(posedge clk);
    check_eq("call", nCall, 32'h1);
    callStart <= 1'b1;
    @(posedge clk);
    callStart <= 1'b0;
    repeat (100) @(posedge clk);
    callResp <= 1'b1;
    @(posedge clk);
    callResp <= 1'b0;
    repeat (4500) @(posedge clk);
    check_eq("callresp", nCall, 32'h1);
    test_done();
  end
endmodule : test_lapb_link_control
`default_nettype wire
